// ---- bgp_board.sv ----
// Board model: pin wires with pull-ups and optional external drivers
`timescale 1ns/100ps
module bgp_board (
    // Design side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    output logic [7:0]      pin_in,
    // External drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val
);
    // Two drivers on one wire give X, so a fight is never hidden
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i] && ext_en[i])
                pin_in[i] = 1'bx;
            else if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule // bgp_board

// ---- bgp_flash.sv ----
// Flash phase generator: one square wave per flashing rate, plus a steady high phase
`timescale 1ns/100ps
module bgp_flash #(
    parameter int unsigned HALF_FAST = bgp_pkg::FLASH_FAST_CYC,
    parameter int unsigned HALF_MID  = bgp_pkg::FLASH_MID_CYC,
    parameter int unsigned HALF_SLOW = bgp_pkg::FLASH_SLOW_CYC
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       rst_n,
    // Phases, bit 0 steady high, bits 1..3 fast to slow
    output logic [3:0]      phase
);
    localparam int unsigned HALF [3] = '{HALF_FAST, HALF_MID, HALF_SLOW};

    assign phase[0] = 1'b1;

    genvar r;
    generate
        for (r = 0; r < 3; r++) begin : g_rate
            logic [31:0] cnt_q;
            logic [31:0] cnt_d;
            logic        ph_q;
            logic        ph_d;

            always_comb begin
                cnt_d = cnt_q + 32'h1;
                ph_d  = ph_q;
                if (cnt_q >= HALF[r] - 1) begin
                    cnt_d = 32'h0;
                    ph_d  = ~ph_q;
                end
            end

            always_ff @(posedge aclk) begin
                if (!rst_n) begin
                    cnt_q <= 32'h0;
                    ph_q  <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    ph_q  <= ph_d;
                end
            end

            assign phase[r + 1] = ph_q;
        end
    endgenerate
endmodule // bgp_flash

// ---- bgp_pkg.sv ----
// Constants and types shared by the bypass-capable GPIO port
package bgp_pkg;

    // Port shape
    localparam int unsigned PINS  = 8;
    localparam int unsigned PAIRS = 4;

    // Register byte offsets
    localparam logic [4:0] OFS_MODE   = 5'h00;
    localparam logic [4:0] OFS_OUT    = 5'h04;
    localparam logic [4:0] OFS_RATE   = 5'h08;
    localparam logic [4:0] OFS_BYPASS = 5'h0C;
    localparam logic [4:0] OFS_LEVEL  = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_MASK   = 5'h18;

    // Bypass register field positions
    localparam int unsigned BYP_EN_LSB   = 0;
    localparam int unsigned BYP_OPEN_LSB = 4;
    localparam int unsigned BYP_SRC_LSB  = 8;

    // Reset values
    localparam logic [15:0] MODE_RST   = 16'h0000;
    localparam logic [7:0]  OUT_RST    = 8'h00;
    localparam logic [15:0] RATE_RST   = 16'h0000;
    localparam logic [11:0] BYPASS_RST = 12'h000;
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [7:0]  OE_N_RST   = 8'hFF;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin driver modes
    typedef enum logic [1:0] {
        BGP_MODE_IN     = 2'h0,
        BGP_MODE_TOTEM  = 2'h1,
        BGP_MODE_DRAIN  = 2'h3,
        BGP_MODE_SOURCE = 2'h2
    } bgp_mode_t;

    // Clock and timing
    localparam int unsigned CLK_KHZ       = 125000;
    localparam int unsigned FLASH_FAST_MS = 125;
    localparam int unsigned FLASH_MID_MS  = 250;
    localparam int unsigned FLASH_SLOW_MS = 500;
    localparam int unsigned FLASH_FAST_CYC = FLASH_FAST_MS * CLK_KHZ;
    localparam int unsigned FLASH_MID_CYC  = FLASH_MID_MS * CLK_KHZ;
    localparam int unsigned FLASH_SLOW_CYC = FLASH_SLOW_MS * CLK_KHZ;
    // Least reset pulse the board controller must give after power-up
    localparam int unsigned RESET_HOLD_MS  = 100;
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CLK_KHZ;

endpackage

// ---- bgp_port.sv ----
// Eight-pin GPIO port with flashing, edge capture and pair bypass
`timescale 1ns/100ps
module bgp_port #(
    parameter int unsigned HALF_FAST = bgp_pkg::FLASH_FAST_CYC,
    parameter int unsigned HALF_MID  = bgp_pkg::FLASH_MID_CYC,
    parameter int unsigned HALF_SLOW = bgp_pkg::FLASH_SLOW_CYC
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [4:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // AXI4-Lite read address
    input  wire logic [4:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // Port pins, port_pin_zero is bit 0, port_pin_seven bit 7
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe_n,
    // Interrupt
    output logic             irq
);
    logic        rst_n;
    logic [3:0]  phase;

    bgp_rst_sync u_rst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rst_n   (rst_n)
    );

    bgp_flash #(
        .HALF_FAST (HALF_FAST),
        .HALF_MID  (HALF_MID),
        .HALF_SLOW (HALF_SLOW)
    ) u_flash (
        .aclk  (aclk),
        .rst_n (rst_n),
        .phase (phase)
    );

    // Configuration and status registers
    logic [15:0] mode_q, mode_d;
    logic [7:0]  out_q, out_d;
    logic [15:0] rate_q, rate_d;
    logic [11:0] byp_q, byp_d;
    logic [7:0]  status_q, status_d;
    logic [7:0]  mask_q, mask_d;
    logic [7:0]  in_q;
    logic [7:0]  prev_q;
    logic        irq_d;

    // Write channel state
    logic        aw_got_q, aw_got_d;
    logic        w_got_q, w_got_d;
    logic [4:0]  waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_d;
    logic [1:0]  bresp_d;
    logic        awready_d, wready_d;
    logic        wr_fire;

    // Read channel state
    logic        arready_d, rvalid_d;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_d;

    // Pin drive
    logic [7:0]  in_mask;
    logic [7:0]  edges;
    logic [7:0]  pin_out_d, pin_oe_n_d;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Write channel: address and data taken in either order
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        waddr_d  = waddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = s_bvalid;
        bresp_d  = s_bresp;
        wr_fire  = aw_got_q && w_got_q && !s_bvalid;
        if (s_awvalid && s_awready) begin
            aw_got_d = 1'b1;
            waddr_d  = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_got_d = 1'b1;
            wdata_d = s_wdata;
            wstrb_d = s_wstrb;
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            if (waddr_q == bgp_pkg::OFS_MODE ||
                waddr_q == bgp_pkg::OFS_OUT ||
                waddr_q == bgp_pkg::OFS_RATE ||
                waddr_q == bgp_pkg::OFS_BYPASS ||
                waddr_q == bgp_pkg::OFS_LEVEL ||
                waddr_q == bgp_pkg::OFS_STATUS ||
                waddr_q == bgp_pkg::OFS_MASK) begin
                bresp_d = bgp_pkg::RESP_OKAY;
            end else begin
                bresp_d = bgp_pkg::RESP_SLVERR;
            end
        end else if (s_bvalid && s_bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_got_d && !bvalid_d;
        wready_d  = !w_got_d && !bvalid_d;
    end

    // Register updates; the level register is read-only
    always_comb begin
        logic [31:0] m;
        m      = merge(32'h0, wdata_q, wstrb_q);
        mode_d = mode_q;
        out_d  = out_q;
        rate_d = rate_q;
        byp_d  = byp_q;
        mask_d = mask_q;
        if (wr_fire) begin
            if (waddr_q == bgp_pkg::OFS_MODE) begin
                mode_d = merge({16'h0, mode_q}, wdata_q, wstrb_q)
                         [15:0];
            end else if (waddr_q == bgp_pkg::OFS_OUT) begin
                out_d = merge({24'h0, out_q}, wdata_q, wstrb_q)[7:0];
            end else if (waddr_q == bgp_pkg::OFS_RATE) begin
                rate_d = merge({16'h0, rate_q}, wdata_q, wstrb_q)
                         [15:0];
            end else if (waddr_q == bgp_pkg::OFS_BYPASS) begin
                byp_d = merge({20'h0, byp_q}, wdata_q, wstrb_q)[11:0];
            end else if (waddr_q == bgp_pkg::OFS_MASK) begin
                mask_d = merge({24'h0, mask_q}, wdata_q, wstrb_q)[7:0];
            end
        end
        // A new edge wins over a clear in the same cycle
        status_d = status_q | edges;
        if (wr_fire && waddr_q == bgp_pkg::OFS_STATUS) begin
            status_d = (status_q & ~m[7:0]) | edges;
        end
        // A set mask bit silences its event
        irq_d = |(status_d & ~mask_d);
    end

    // Read channel: one cycle from address to data
    always_comb begin
        arready_d = s_arready;
        rvalid_d  = s_rvalid;
        rdata_d   = s_rdata;
        rresp_d   = s_rresp;
        if (s_arvalid && s_arready) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = bgp_pkg::RESP_OKAY;
            if (s_araddr == bgp_pkg::OFS_MODE) begin
                rdata_d = {16'h0, mode_q};
            end else if (s_araddr == bgp_pkg::OFS_OUT) begin
                rdata_d = {24'h0, out_q};
            end else if (s_araddr == bgp_pkg::OFS_RATE) begin
                rdata_d = {16'h0, rate_q};
            end else if (s_araddr == bgp_pkg::OFS_BYPASS) begin
                rdata_d = {20'h0, byp_q};
            end else if (s_araddr == bgp_pkg::OFS_LEVEL) begin
                rdata_d = {24'h0, in_q};
            end else if (s_araddr == bgp_pkg::OFS_STATUS) begin
                rdata_d = {24'h0, status_q};
            end else if (s_araddr == bgp_pkg::OFS_MASK) begin
                rdata_d = {24'h0, mask_q};
            end else begin
                rdata_d = 32'h0;
                rresp_d = bgp_pkg::RESP_SLVERR;
            end
        end else if (s_rvalid && s_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
        // No new address while read data still waits
        arready_d = !rvalid_d;
    end

    assign edges = (in_q ^ prev_q) & in_mask;

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= 5'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= bgp_pkg::RESP_OKAY;
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= bgp_pkg::RESP_OKAY;
            mode_q    <= bgp_pkg::MODE_RST;
            out_q     <= bgp_pkg::OUT_RST;
            rate_q    <= bgp_pkg::RATE_RST;
            byp_q     <= bgp_pkg::BYPASS_RST;
            status_q  <= bgp_pkg::STATUS_RST;
            mask_q    <= bgp_pkg::MASK_RST;
            // Pulled-up idle level, so leaving reset makes no false edge
            in_q      <= 8'hFF;
            prev_q    <= 8'hFF;
            irq       <= 1'b0;
            pin_out   <= 8'h00;
            pin_oe_n  <= bgp_pkg::OE_N_RST;
        end else begin
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            s_awready <= awready_d;
            s_wready  <= wready_d;
            s_bvalid  <= bvalid_d;
            s_bresp   <= bresp_d;
            s_arready <= arready_d;
            s_rvalid  <= rvalid_d;
            s_rdata   <= rdata_d;
            s_rresp   <= rresp_d;
            mode_q    <= mode_d;
            out_q     <= out_d;
            rate_q    <= rate_d;
            byp_q     <= byp_d;
            status_q  <= status_d;
            mask_q    <= mask_d;
            in_q      <= pin_in;
            prev_q    <= in_q;
            irq       <= irq_d;
            pin_out   <= pin_out_d;
            pin_oe_n  <= pin_oe_n_d;
        end
    end

    // Per-pin drivers
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            localparam int unsigned P = i / 2;
            logic       drv;
            logic [1:0] kind;
            logic       o;
            logic       oe_n;

            always_comb begin
                drv  = out_q[i] & phase[rate_q[2*i +: 2]];
                kind = mode_q[2*i +: 2];
                o    = 1'b0;
                oe_n = 1'b1;
                if (i % 2 == 1 && byp_q[bgp_pkg::BYP_EN_LSB + P]) begin
                    drv = in_q[i ^ 1];
                    if (!byp_q[bgp_pkg::BYP_OPEN_LSB + P]) begin
                        kind = bgp_pkg::BGP_MODE_TOTEM;
                    end else if (byp_q[bgp_pkg::BYP_SRC_LSB + P]) begin
                        kind = bgp_pkg::BGP_MODE_SOURCE;
                    end else begin
                        kind = bgp_pkg::BGP_MODE_DRAIN;
                    end
                end
                // Open drivers release the pin for their passive level
                case (kind)
                    bgp_pkg::BGP_MODE_TOTEM: begin
                        o    = drv;
                        oe_n = 1'b0;
                    end
                    bgp_pkg::BGP_MODE_DRAIN: oe_n = drv;
                    bgp_pkg::BGP_MODE_SOURCE: begin
                        o    = 1'b1;
                        oe_n = !drv;
                    end
                    default: ;
                endcase
            end

            assign in_mask[i]    = (kind == bgp_pkg::BGP_MODE_IN);
            assign pin_out_d[i]  = o;
            assign pin_oe_n_d[i] = oe_n;
        end
    endgenerate

    bvalid_hold_a: assert property (
        @(posedge aclk) disable iff (!rst_n)
        s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped before taken");

    rdata_hold_a: assert property (
        @(posedge aclk) disable iff (!rst_n)
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data changed before taken");

    irq_level_a: assert property (
        @(posedge aclk) disable iff (!rst_n)
        |(status_q & ~mask_q) |-> irq)
        else $error("unmasked event without interrupt");

    edge_kept_a: assert property (
        @(posedge aclk) disable iff (!rst_n)
        !(wr_fire && waddr_q == bgp_pkg::OFS_STATUS)
        |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("recorded edge lost without a clear");

    bypass_follow_a: assert property (
        @(posedge aclk) disable iff (!rst_n)
        byp_q[1] && !byp_q[5]
        |=> !pin_oe_n[3] && pin_out[3] == $past(in_q[2]))
        else $error("bypass pin not following its pair");
endmodule // bgp_port

// ---- bgp_rst_sync.sv ----
// Reset conditioner: asynchronous assertion, clocked release
`timescale 1ns/100ps
module bgp_rst_sync (
    // Clock and raw reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Conditioned reset
    output logic      rst_n
);
    logic meta_q;
    logic hold_q;

    // First stage feeds only the second stage
    always_ff @(posedge aclk or negedge aresetn) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            hold_q <= meta_q;
        end
    end

    assign rst_n = hold_q;

    reset_async_a: assert property (
        @(posedge aclk) !aresetn |=> !rst_n)
        else $error("reset not applied while input low");
endmodule // bgp_rst_sync

// ---- bypass_capable_gpio_port_test.sv ----
// Self-checking bench for the bypass-capable GPIO port
`timescale 1ns/100ps
module bypass_capable_gpio_port_test;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  pin_in, pin_out, pin_oe_n;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
    logic [31:0] d;
    logic        p0, p1;
    int          n_fail = 0, cmp_count = 0, t0, t1;

    always #4 aclk = ~aclk;

    // Short flash periods keep the run brief
    bgp_port #(.HALF_FAST(4), .HALF_MID(8), .HALF_SLOW(16)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rvalid), .s_rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));

    bgp_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_in(pin_in), .ext_en(ext_en), .ext_val(ext_val));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bit done;
        done = 0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic rd(input logic [4:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    logic [4:0]  ofs[6] = '{bgp_pkg::OFS_MODE, bgp_pkg::OFS_OUT,
        bgp_pkg::OFS_RATE, bgp_pkg::OFS_BYPASS, bgp_pkg::OFS_STATUS,
        bgp_pkg::OFS_MASK};
    logic [31:0] rv[6] = '{32'(bgp_pkg::MODE_RST), 32'(bgp_pkg::OUT_RST),
        32'(bgp_pkg::RATE_RST), 32'(bgp_pkg::BYPASS_RST),
        32'(bgp_pkg::STATUS_RST), 32'(bgp_pkg::MASK_RST)};
    bgp_pkg::bgp_mode_t md[4] = '{bgp_pkg::BGP_MODE_IN,
        bgp_pkg::BGP_MODE_TOTEM, bgp_pkg::BGP_MODE_DRAIN,
        bgp_pkg::BGP_MODE_SOURCE};
    logic [7:0]  eoe[4] = '{8'hFF, 8'h00, 8'h55, 8'hAA};
    // Bypass word, even-pin level, expected odd enable and level
    logic [31:0] bw[4] = '{32'h002, 32'h002, 32'h022, 32'h222};
    logic [3:0]  bx[4] = '{4'h5, 4'h0, 4'hB, 4'h2};

    initial begin
        // Only the power-up reset: a legal later one outlasts the run
        tick(6);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i]); chk(d, rv[i]);
        end
        chk(pin_oe_n, bgp_pkg::OE_N_RST);
        chk(irq, 1'b0);
        rd(5'h1C); chk(r, bgp_pkg::RESP_SLVERR);
        $display("test reset values done");
        wr(bgp_pkg::OFS_OUT, 32'h55);
        for (int m = 0; m < 4; m++) begin
            wr(bgp_pkg::OFS_MODE, {16'h0000, {8{md[m]}}});
            tick(2);
            chk(pin_oe_n, eoe[m]);
            chk(pin_out & ~pin_oe_n, 8'h55 & ~eoe[m]);
        end
        $display("test pin modes done");
        wr(bgp_pkg::OFS_MODE, 32'h0);
        ext_en <= 8'hFF;
        tick(6);
        wr(bgp_pkg::OFS_STATUS, 32'hFF);
        tick(2); chk(irq, 1'b0);
        // One-cycle pulse must survive until software clears it
        @(posedge aclk) ext_val <= 8'h08;
        @(posedge aclk) ext_val <= 8'h00;
        tick(20);
        rd(bgp_pkg::OFS_STATUS); chk(d, 32'h08);
        chk(irq, 1'b1);
        wr(bgp_pkg::OFS_MASK, 32'hFF); tick(2); chk(irq, 1'b0);
        wr(bgp_pkg::OFS_MASK, 32'h00); tick(2); chk(irq, 1'b1);
        wr(bgp_pkg::OFS_STATUS, 32'h08);
        rd(bgp_pkg::OFS_STATUS); chk(d, 32'h0);
        chk(irq, 1'b0);
        ext_val <= 8'hA5;
        tick(6);
        rd(bgp_pkg::OFS_LEVEL); chk(d, 32'hA5);
        $display("test edge capture done");
        ext_en <= 8'h55;
        for (int k = 0; k < 4; k++) begin
            wr(bgp_pkg::OFS_BYPASS, bw[k]);
            ext_val <= {5'h00, bx[k][0], 2'h0};
            tick(6);
            chk(pin_oe_n[3], bx[k][1]);
            chk(pin_out[3] | pin_oe_n[3], bx[k][2] | bx[k][1]);
            chk(pin_oe_n[1], 1'b1);
        end
        $display("test bypass done");
        wr(bgp_pkg::OFS_BYPASS, 32'h0);
        ext_en <= 8'h00;
        wr(bgp_pkg::OFS_MODE, {16'h0000, {8{bgp_pkg::BGP_MODE_TOTEM}}});
        wr(bgp_pkg::OFS_OUT, 32'h03);
        wr(bgp_pkg::OFS_RATE, 32'h000D);
        t0 = 0; t1 = 0;
        p0 = pin_out[0];
        p1 = pin_out[1];
        repeat (96) begin
            @(posedge aclk);
            if (pin_out[0] !== p0) t0++;
            if (pin_out[1] !== p1) t1++;
            p0 = pin_out[0];
            p1 = pin_out[1];
        end
        chk(32'(t0 >= 23 && t0 <= 25), 32'h1);
        chk(32'(t1 >= 5 && t1 <= 7), 32'h1);
        $display("test flashing done");
        tally_and_finish();
    end

    initial begin
        tick(20000);
        n_fail++;
        tally_and_finish();
    end
endmodule // bypass_capable_gpio_port_test
